/* rtl/hfs_pkg.sv */
package hfs_pkg;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int unsigned CLK_HZ = 10_000_000;
    localparam int unsigned PG_DEGLITCH_MS = 9;
    localparam int unsigned PG_DEGLITCH_CYC = PG_DEGLITCH_MS * (CLK_HZ / 1000);
    localparam int unsigned POR_HOLD_MS = 400;
    localparam int unsigned POR_HOLD_CYC = POR_HOLD_MS * (CLK_HZ / 1000);
    localparam int unsigned RETRY_CYCLES = 16;
    localparam int unsigned CNT_W = 32;
    localparam logic [4:0] RETRY_CNT_ZERO = 5'h00;
    localparam logic [CNT_W-1:0] CNT_ZERO = 32'h0000_0000;
    localparam logic [CNT_W-1:0] CNT_ONE = 32'h0000_0001;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef enum logic [2:0]
    {
        HFS_OFF,
        HFS_RUN,
        HFS_LATCHED,
        HFS_RETRY_DIS,
        HFS_RETRY_CHG
    } hfs_state_t;

    // Synchronised comparator flags.
    typedef struct packed
    {
        logic enable_hi;
        logic por_ok;
        logic undervoltage_lockout_ok;
        logic limiting;
        logic timer_hi;
        logic timer_lo;
        logic vds_low;
        logic vds_high;
    } hfs_cmp_t;

    // Control outputs.
    typedef struct packed
    {
        logic gate_enable;
        logic gate_soft_pulldown;
        logic gate_force_low;
        logic power_limit_program_discharge;
        logic timer_charge;
        logic timer_discharge;
        logic power_good_out;
        logic vref_enable;
        logic limiting_active;
    } hfs_ctl_t;

endpackage

/* rtl/hfs_sequencer.sv */
`timescale 1ns/1ps
// Contract
// [R1] Gate enabled only with enable high and POR and lockout satisfied.
// [R2] Latch-off exits only on enable low-then-high or lockout cycle.
// [R3] Enable or lockout turn-off selects the moderate soft gate pulldown.
// [R4] Power good asserts after low drain-source voltage held 9 ms.
// [R5] Power good low while enable false, lockout active, or high drain-source.
// [R6] Brief events are filtered by the 9 ms deglitch.
// [R7] Gate fully on below allowed current, else flag limiting active.
// [R8] Power-limit pin discharged when not enabled or latched off.
// [R9] Timer charges while limiting, discharges at tenth rate otherwise.
// [R10] Latch-off variant: upper timer threshold forces gate low and latches.
// [R11] Auto-retry: gate low, discharge to 1 V, 15 more cycles, re-enable.
// [R12] Timer discharges when enable low or lockout or POR active.
// [R13] No gate drive until POR held 400 ms and lockout exceeded.
// [R14] Lockout or POR holds gate, power-limit pin, power good, timer low.
// [R15] Reference output enabled only after POR and lockout are met.
// [R16] Auto-retry counts 16 timer cycles, repeating while fault persists.
// [R17] Thresholds are synchronised flags; counters restart on qualifying edges.
// [R18] Variant input is static, captured while the supply is not yet qualified.
module hfs_sequencer #(
    parameter int unsigned DEGLITCH_CYC = hfs_pkg::PG_DEGLITCH_CYC,
    parameter int unsigned POR_CYC = hfs_pkg::POR_HOLD_CYC
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_ce,
    input wire logic i_auto_retry,
    input wire hfs_pkg::hfs_cmp_t i_cmp,
    output hfs_pkg::hfs_ctl_t o_ctl
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed
    {
        hfs_pkg::hfs_cmp_t s1;
        hfs_pkg::hfs_cmp_t s2;
        hfs_pkg::hfs_state_t st;
        logic auto_retry;
        logic variant_s1;
        logic variant_s2;
        logic [hfs_pkg::CNT_W-1:0] por_cnt;
        logic [hfs_pkg::CNT_W-1:0] pg_cnt;
        logic [4:0] retry_cnt;
        hfs_pkg::hfs_ctl_t ctl;
    } hfs_regs_t;

    hfs_regs_t r_reg;
    hfs_regs_t r_next;
    logic supply_ok;
    logic por_done;

    assign por_done = r_reg.por_cnt >= POR_CYC[hfs_pkg::CNT_W-1:0];
    assign supply_ok = por_done && r_reg.s2.undervoltage_lockout_ok; // see [R13]

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb
    begin
        r_next = r_reg;
        r_next.s1 = i_cmp; // see [R17]
        r_next.s2 = r_reg.s1;
        r_next.variant_s1 = i_auto_retry;
        r_next.variant_s2 = r_reg.variant_s1;
        // The strap is followed only until the supply qualifies, so it cannot change
        // the fault behaviour while the gate may be driven.
        if (!supply_ok)
        begin
            r_next.auto_retry = r_reg.variant_s2; // see [R18]
        end
        // POR hold timer restarts whenever the POR comparator drops.
        if (!r_reg.s2.por_ok)
        begin
            r_next.por_cnt = hfs_pkg::CNT_ZERO;
        end
        else if (!por_done)
        begin
            r_next.por_cnt = r_reg.por_cnt + hfs_pkg::CNT_ONE; // see [R13]
        end
        unique case (r_reg.st)
            hfs_pkg::HFS_OFF:
            begin
                if (supply_ok && r_reg.s2.enable_hi)
                begin
                    r_next.st = hfs_pkg::HFS_RUN; // see [R1]
                end
            end
            hfs_pkg::HFS_RUN:
            begin
                if (!supply_ok || !r_reg.s2.enable_hi)
                begin
                    r_next.st = hfs_pkg::HFS_OFF;
                end
                else if (r_reg.s2.timer_hi)
                begin
                    r_next.st = r_reg.auto_retry ? hfs_pkg::HFS_RETRY_DIS
                                                 : hfs_pkg::HFS_LATCHED; // see [R10]
                    r_next.retry_cnt = hfs_pkg::RETRY_CNT_ZERO;
                end
            end
            hfs_pkg::HFS_LATCHED:
            begin
                // Leaves only on lockout/POR loss or an enable falling edge.
                if (!supply_ok || !r_reg.s2.enable_hi)
                begin
                    r_next.st = hfs_pkg::HFS_OFF; // see [R2]
                end
            end
            hfs_pkg::HFS_RETRY_DIS:
            begin
                if (!supply_ok || !r_reg.s2.enable_hi)
                begin
                    r_next.st = hfs_pkg::HFS_OFF;
                end
                else if (r_reg.s2.timer_lo)
                begin
                    if (r_reg.retry_cnt == 5'(hfs_pkg::RETRY_CYCLES - 1))
                    begin
                        r_next.st = hfs_pkg::HFS_RUN; // see [R11] see [R16]
                    end
                    else
                    begin
                        r_next.st = hfs_pkg::HFS_RETRY_CHG;
                        r_next.retry_cnt = r_reg.retry_cnt + 5'h01;
                    end
                end
            end
            hfs_pkg::HFS_RETRY_CHG:
            begin
                if (!supply_ok || !r_reg.s2.enable_hi)
                begin
                    r_next.st = hfs_pkg::HFS_OFF;
                end
                else if (r_reg.s2.timer_hi)
                begin
                    r_next.st = hfs_pkg::HFS_RETRY_DIS;
                end
            end
            default:
            begin
                r_next.st = hfs_pkg::HFS_OFF;
            end
        endcase

        // Power good rises after a full deglitch of low drain-source voltage and,
        // once up, rides out in-band dips shorter than the same deglitch.
        if (r_next.st != hfs_pkg::HFS_RUN || r_reg.s2.vds_high)
        begin
            r_next.pg_cnt = hfs_pkg::CNT_ZERO; // see [R5]
        end
        else if (r_reg.s2.vds_low)
        begin
            if (r_reg.ctl.power_good_out)
            begin
                r_next.pg_cnt = DEGLITCH_CYC[hfs_pkg::CNT_W-1:0]; // see [R17]
            end
            else if (r_reg.pg_cnt < DEGLITCH_CYC[hfs_pkg::CNT_W-1:0])
            begin
                r_next.pg_cnt = r_reg.pg_cnt + hfs_pkg::CNT_ONE; // see [R4]
            end
        end
        else if (!r_reg.ctl.power_good_out)
        begin
            r_next.pg_cnt = hfs_pkg::CNT_ZERO;
        end
        else if (r_reg.pg_cnt != hfs_pkg::CNT_ZERO)
        begin
            r_next.pg_cnt = r_reg.pg_cnt - hfs_pkg::CNT_ONE; // see [R6]
        end

        r_next.ctl.gate_enable = (r_next.st == hfs_pkg::HFS_RUN); // see [R1] see [R14]
        r_next.ctl.limiting_active = r_next.ctl.gate_enable && r_reg.s2.limiting; // see [R7]
        r_next.ctl.gate_soft_pulldown = (r_next.st == hfs_pkg::HFS_OFF); // see [R3]
        r_next.ctl.gate_force_low = !r_next.ctl.gate_enable && !r_next.ctl.gate_soft_pulldown;
        r_next.ctl.power_limit_program_discharge = !r_next.ctl.gate_enable; // see [R8]
        r_next.ctl.timer_charge = (r_next.st == hfs_pkg::HFS_RETRY_CHG)
            || (r_next.ctl.gate_enable && r_reg.s2.limiting); // see [R9]
        r_next.ctl.timer_discharge = !r_next.ctl.timer_charge; // see [R12]
        r_next.ctl.power_good_out = r_reg.ctl.power_good_out
            ? (r_next.pg_cnt != hfs_pkg::CNT_ZERO)
            : (r_next.pg_cnt >= DEGLITCH_CYC[hfs_pkg::CNT_W-1:0]); // see [R4] see [R6]
        r_next.ctl.vref_enable = supply_ok; // see [R15]
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            r_reg <= '0;
            r_reg.st <= hfs_pkg::HFS_OFF;
            r_reg.ctl.gate_soft_pulldown <= 1'b1;
            r_reg.ctl.power_limit_program_discharge <= 1'b1;
            r_reg.ctl.timer_discharge <= 1'b1;
        end
        else if (i_ce)
        begin
            r_reg <= r_next;
        end
    end

    assign o_ctl = r_reg.ctl;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    property p_gate_needs_supply;
        @(posedge i_clk) disable iff (i_rst)
        o_ctl.gate_enable |-> $past(supply_ok) || !$past(i_ce);
    endproperty
    a_gate_needs_supply: assert property (p_gate_needs_supply) // see [R1] see [R13]
        else $error("Gate enabled without supply qualified.");

    property p_latched_holds;
        @(posedge i_clk) disable iff (i_rst)
        (i_ce && r_reg.st == hfs_pkg::HFS_LATCHED && supply_ok && r_reg.s2.enable_hi)
        |=> r_reg.st == hfs_pkg::HFS_LATCHED;
    endproperty
    a_latched_holds: assert property (p_latched_holds) // see [R2]
        else $error("Latched state left without enable or supply cycle.");

    property p_soft_pd;
        @(posedge i_clk) disable iff (i_rst)
        (r_reg.st == hfs_pkg::HFS_OFF) |-> o_ctl.gate_soft_pulldown && !o_ctl.gate_enable;
    endproperty
    a_soft_pd: assert property (p_soft_pd) // see [R3]
        else $error("Soft pulldown not selected while off.");

    property p_pg_deglitch;
        @(posedge i_clk) disable iff (i_rst)
        $rose(o_ctl.power_good_out) |-> r_reg.pg_cnt == DEGLITCH_CYC[hfs_pkg::CNT_W-1:0];
    endproperty
    a_pg_deglitch: assert property (p_pg_deglitch) // see [R4] see [R6]
        else $error("Power good rose before deglitch completed.");

    property p_pg_low;
        @(posedge i_clk) disable iff (i_rst)
        (i_ce && (!r_reg.s2.enable_hi || r_reg.s2.vds_high || !r_reg.s2.undervoltage_lockout_ok))
        |=> !o_ctl.power_good_out;
    endproperty
    a_pg_low: assert property (p_pg_low) // see [R5] see [R14]
        else $error("Power good high during a disqualifying condition.");

    property p_power_limit_program;
        @(posedge i_clk) disable iff (i_rst)
        (r_reg.st == hfs_pkg::HFS_LATCHED) |-> o_ctl.power_limit_program_discharge;
    endproperty
    a_power_limit_program: assert property (p_power_limit_program) // see [R8]
        else $error("Power-limit pin released while latched off.");

    property p_timer_excl;
        @(posedge i_clk) disable iff (i_rst)
        o_ctl.timer_charge != o_ctl.timer_discharge;
    endproperty
    a_timer_excl: assert property (p_timer_excl) // see [R9] see [R12]
        else $error("Timer charge and discharge not exclusive.");

    property p_fault_trip;
        @(posedge i_clk) disable iff (i_rst)
        (i_ce && r_reg.st == hfs_pkg::HFS_RUN && supply_ok && r_reg.s2.enable_hi
            && r_reg.s2.timer_hi) |=> !o_ctl.gate_enable;
    endproperty
    a_fault_trip: assert property (p_fault_trip) // see [R10] see [R11]
        else $error("Gate still enabled after timer fault.");

    property p_vref;
        @(posedge i_clk) disable iff (i_rst)
        (i_ce && !supply_ok) |=> !o_ctl.vref_enable;
    endproperty
    a_vref: assert property (p_vref) // see [R15]
        else $error("Reference enabled before supply qualified.");

    property p_pg_hold;
        @(posedge i_clk) disable iff (i_rst)
        (i_ce && o_ctl.power_good_out && r_reg.pg_cnt > hfs_pkg::CNT_ONE
            && r_next.st == hfs_pkg::HFS_RUN && !r_reg.s2.vds_high) |=> o_ctl.power_good_out;
    endproperty
    a_pg_hold: assert property (p_pg_hold) // see [R6]
        else $error("Power good dropped during a brief in-band dip.");

    property p_retry_count;
        @(posedge i_clk) disable iff (i_rst)
        (i_ce && r_reg.st == hfs_pkg::HFS_RETRY_DIS && supply_ok && r_reg.s2.enable_hi
            && r_reg.s2.timer_lo && r_reg.retry_cnt == 5'(hfs_pkg::RETRY_CYCLES - 1))
        |=> o_ctl.gate_enable;
    endproperty
    a_retry_count: assert property (p_retry_count) // see [R16]
        else $error("Gate not re-enabled after the last retry cycle.");

endmodule // hfs_sequencer

/* test/hfs_partner.sv */
`timescale 1ns/1ps
// Pass device, load and timer capacitor, in tenths of a volt.
module hfs_partner (
    input wire logic i_clk,
    input wire hfs_pkg::hfs_ctl_t i_ctl,
    input wire logic i_short,
    input wire logic i_bump,
    output logic o_limiting,
    output logic o_timer_hi,
    output logic o_timer_lo,
    output logic o_vds_low,
    output logic o_vds_high
);
    int cap = 0;
    int vds = 120;
    always @(posedge i_clk)
    begin
        if (i_ctl.timer_charge)
            cap <= cap + 10;
        else if (i_ctl.timer_discharge && cap > 0)
            cap <= cap - 1;
        if (!i_ctl.gate_enable || i_short)
            vds <= 120;
        else
            vds <= (vds >= 10) ? vds - 10 : 0;
    end
    // A bump lifts the drain-source voltage into the band between both thresholds.
    assign o_limiting = i_short && i_ctl.gate_enable;
    assign o_timer_hi = cap >= 40;
    assign o_timer_lo = cap <= 10;
    assign o_vds_low = (vds + (i_bump ? 20 : 0)) < 13;
    assign o_vds_high = vds > 27;
endmodule // hfs_partner

/* test/hfs_sequencer_tb_top.sv */
`timescale 1ns/1ps
module hfs_sequencer_tb_top;
    localparam int DEG = 10;
    localparam int POR = 20;
    localparam int GATE = 8;
    localparam int FORCE = 6;
    localparam int LIM = 0;
    localparam int PG = 2;
    logic i_clk, i_rst, i_ce, en, por, uv, short_r, bump, variant;
    logic lim, thi, tlo, vl, vh;
    int errors, cmp_count, n;
    logic [15:0] lfsr;
    hfs_pkg::hfs_cmp_t cmp;
    hfs_pkg::hfs_ctl_t ctl;
    assign cmp = {en, por, uv, lim, thi, tlo, vl, vh};
    hfs_sequencer #(.DEGLITCH_CYC(DEG), .POR_CYC(POR)) i_dut (.i_clk(i_clk), .i_rst(i_rst),
        .i_ce(i_ce), .i_auto_retry(variant), .i_cmp(cmp), .o_ctl(ctl));
    hfs_partner i_far (.i_clk(i_clk), .i_ctl(ctl), .i_short(short_r), .i_bump(bump),
        .o_limiting(lim), .o_timer_hi(thi), .o_timer_lo(tlo), .o_vds_low(vl), .o_vds_high(vh));
    // ------------------------------------------------------------------
    // Reference model and helpers
    // ------------------------------------------------------------------
    function automatic logic [8:0] exp_ctl(input logic pw, input logic on, input logic lat,
        input logic pgv);
        logic g;
        g = pw & on & !lat;
        return {g, !(pw & on), pw & on & lat, !g, 1'b0, 1'b1, pgv, pw, 1'b0};
    endfunction
    function automatic logic [15:0] lfsr_next(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    task automatic chk(input logic [8:0] seen, input logic [8:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            errors++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic cyc(input int k);
        repeat (k) @(posedge i_clk);
        #1;
    endtask
    task automatic wait_bit(input int idx, input logic v, input int lim_c);
        n = 0;
        while (ctl[idx] !== v && n < lim_c)
        begin
            cyc(1);
            n++;
        end
        if (n >= lim_c)
        begin
            errors++;
            $display("[ERR] %0t wait limit reached", $time);
        end
    endtask
    task automatic end_of_test;
        $display("comparisons %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    initial
    begin
        i_clk = 1'b0;
        forever #50 i_clk = ~i_clk;
    end
    initial
    begin
        repeat (5000) @(posedge i_clk);
        errors++;
        $display("[ERR] %0t watchdog expired", $time);
        end_of_test;
    end
    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    initial
    begin
        {i_rst, i_ce, en, por, uv, short_r, bump} = 7'b1100000;
        variant = 1'b0;
        errors = 0;
        cmp_count = 0;
        lfsr = 16'h5F34;
        repeat (10) @(posedge i_clk);
        i_rst <= 1'b0;
        cyc(1);
        chk(ctl, exp_ctl(1'b0, 1'b0, 1'b0, 1'b0));
        i_ce <= 1'b0;
        {en, por, uv} <= 3'b111;
        cyc(30);
        chk(ctl, exp_ctl(1'b0, 1'b0, 1'b0, 1'b0));
        $display("reset and freeze test done");
        i_ce <= 1'b1;
        cyc(POR);
        chk({8'h00, ctl.gate_enable}, 9'h000);
        wait_bit(GATE, 1'b1, 40);
        chk(ctl, exp_ctl(1'b1, 1'b1, 1'b0, 1'b0));
        wait_bit(PG, 1'b1, 60);
        chk({8'h00, n >= DEG}, 9'h001);
        chk(ctl, exp_ctl(1'b1, 1'b1, 1'b0, 1'b1));
        $display("power up test done");
        for (int i = 0; i < 4; i++)
        begin
            lfsr = lfsr_next(lfsr);
            @(posedge i_clk);
            bump <= 1'b1;
            cyc(1 + int'(lfsr[2:0] % 3'h5));
            bump <= 1'b0;
            cyc(3);
            chk({8'h00, ctl.power_good_out}, 9'h001);
            cyc(DEG + 2);
            chk({8'h00, ctl.power_good_out}, 9'h001);
        end
        @(posedge i_clk);
        bump <= 1'b1;
        cyc(DEG + 5);
        bump <= 1'b0;
        chk({8'h00, ctl.power_good_out}, 9'h000);
        $display("deglitch test done");
        @(posedge i_clk);
        short_r <= 1'b1;
        wait_bit(LIM, 1'b1, 10);
        chk({6'h00, ctl.gate_enable, ctl.timer_charge, ctl.timer_discharge}, 9'h006);
        wait_bit(FORCE, 1'b1, 30);
        chk({8'h00, n < 30}, 9'h001);
        short_r <= 1'b0;
        cyc(100);
        chk(ctl, exp_ctl(1'b1, 1'b1, 1'b1, 1'b0));
        en <= 1'b0;
        cyc(6);
        chk(ctl, exp_ctl(1'b1, 1'b0, 1'b0, 1'b0));
        en <= 1'b1;
        wait_bit(GATE, 1'b1, 10);
        chk({8'h00, ctl.gate_enable}, 9'h001);
        $display("latch off test done");
        wait_bit(PG, 1'b1, 60);
        chk({8'h00, ctl.power_good_out}, 9'h001);
        uv <= 1'b0;
        cyc(6);
        chk(ctl, exp_ctl(1'b0, 1'b1, 1'b0, 1'b0));
        $display("lockout test done");
        i_rst <= 1'b1;
        variant <= 1'b1;
        uv <= 1'b1;
        cyc(2);
        i_rst <= 1'b0;
        cyc(1);
        chk(ctl, exp_ctl(1'b0, 1'b1, 1'b0, 1'b0));
        wait_bit(GATE, 1'b1, 40);
        short_r <= 1'b1;
        wait_bit(FORCE, 1'b1, 30);
        chk(ctl, exp_ctl(1'b1, 1'b1, 1'b1, 1'b0));
        wait_bit(4, 1'b1, 200);
        chk({7'h00, ctl.gate_enable, ctl.timer_charge}, 9'h001);
        wait_bit(GATE, 1'b1, 2000);
        chk({8'h00, n >= 15 * 30}, 9'h001);
        wait_bit(FORCE, 1'b1, 30);
        chk({8'h00, ctl.gate_force_low}, 9'h001);
        short_r <= 1'b0;
        en <= 1'b0;
        cyc(6);
        chk(ctl, exp_ctl(1'b1, 1'b0, 1'b0, 1'b0));
        $display("auto retry test done");
        end_of_test;
    end
endmodule // hfs_sequencer_tb_top
